// ### verilog/sltf_regs.svh
`ifndef SLTF_REGS_SVH
`define SLTF_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte address = 4 * index)
// ----------------------------------------------------------------------
`define SLTF_IDX_TEST      12'h205
`define SLTF_IDX_DID       12'h206
`define SLTF_IDX_FRAME_END 12'h207
`define SLTF_IDX_STATUS    12'h208

// ----------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------
`define SLTF_RST_TEST      5'h00
`define SLTF_RST_DID       8'h00
`define SLTF_RST_FRAME_END 2'h0
`define SLTF_STAT_LINK_UP  6
`define SLTF_STAT_SYNC     5
`define SLTF_STAT_REALIGN  4
`define SLTF_STAT_MULTIFRAME_PHASE_SET_FLAG  3
`define SLTF_STAT_LOCK     2

// ----------------------------------------------------------------------
// Pattern codes and characters
// ----------------------------------------------------------------------
`define SLTF_TP_OFF        5'h00
`define SLTF_TP_PRBS7      5'h01
`define SLTF_TP_PRBS15     5'h02
`define SLTF_TP_PRBS23     5'h03
`define SLTF_TP_RAMP       5'h04
`define SLTF_TP_TRANSPORT  5'h05
`define SLTF_TP_D215       5'h06
`define SLTF_TP_K285       5'h07
`define SLTF_TP_ILA        5'h08
`define SLTF_TP_RPAT       5'h09
`define SLTF_TP_LOW        5'h0A
`define SLTF_TP_HIGH       5'h0B
`define SLTF_TP_PRBS9      5'h0D
`define SLTF_TP_PRBS31     5'h0E
`define SLTF_TP_CLOCK      5'h0F
`define SLTF_TP_K287       5'h10
`define SLTF_CLOCK_WORD    16'h00FF
`define SLTF_K28_7         8'hFC
`define SLTF_K28_1         8'h3C
`define SLTF_K28_5         8'hBC
`define SLTF_D21_5         8'hB5

`endif

// ### verilog/sltf_pkg.sv
package sltf_pkg;

    typedef enum logic [3:0] {
        SLTF_SRC_DATA,
        SLTF_SRC_PRBS,
        SLTF_SRC_RAMP,
        SLTF_SRC_TRANSPORT,
        SLTF_SRC_CHAR,
        SLTF_SRC_ILA,
        SLTF_SRC_RPAT,
        SLTF_SRC_LOW,
        SLTF_SRC_HIGH,
        SLTF_SRC_CLOCK
    } sltf_src_t;

    typedef enum logic [2:0] {
        SLTF_PRBS_NONE,
        SLTF_PRBS_7,
        SLTF_PRBS_9,
        SLTF_PRBS_15,
        SLTF_PRBS_23,
        SLTF_PRBS_31
    } sltf_prbs_t;

    // Decoded lane configuration handed to the link layer
    typedef struct packed {
        sltf_src_t  source;
        sltf_prbs_t prbs;
        logic [7:0] char_code;
        logic       char_is_k;
        logic [15:0] static_word;
        logic [7:0] did_link_a;
        logic [7:0] did_link_b;
        logic [7:0] frame_end_char;
        logic       frame_end_en;
    } sltf_cfg_t;

    // Link condition inputs
    typedef struct packed {
        logic link_up;
        logic sync_req_n;
        logic pll_locked;
        logic sysref_event;
        logic phase_shift;
    } sltf_link_t;

endpackage : sltf_pkg

// ### verilog/sltf_top.sv
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "sltf_regs.svh"
// Behaviour
// - Five-bit pattern select, zero means normal data
// - Codes 1,2,3 give PRBS7, PRBS15, PRBS23
// - Codes 13,14 give PRBS9, PRBS31
// - Code 4 ramp, code 5 transport pattern
// - Codes 6,7,8,9,16 give characters, ILA, RPAT
// - Code 10 lanes low, code 11 high
// - Code 15 emits 0x00FF clock word
// - Eight-bit identifier in second ILA multiframe
// - Link A sends identifier, link B plus one
// - Identifier bit zero always stored as zero
// - Frame-end select: K28.7, K28.1, K28.5, reserved
// - Frame-end character inserted opportunistically only
// - Frame-end select ignored in 64b/66b modes
// - Status bits 6..2: up, sync, realign, multiframe_phase_set_flag, lock
// - Multiframe_phase_set_flag flag sets on first event, W1C
// - Realign flag sets on phase shift, W1C
// - Sync bit reads inverse of sync request
// - Lock and link-up bits follow live state
module sltf_top
    import sltf_pkg::*;
#(
    parameter int ADR_W = 14
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    output logic                  wb_err_o,
    input  wire logic             link_enable_i,
    input  wire logic             link_mode_8b10b_i,
    input  wire logic             frame_end_ok_i,
    input  wire sltf_pkg::sltf_link_t link_i,
    output sltf_pkg::sltf_cfg_t   cfg_o,
    output logic                  frame_end_insert_o
);
    import sltf_pkg::*;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic             req;
    logic [ADR_W-3:0] idx;
    logic             hit_test;
    logic             hit_did;
    logic             hit_frame_end;
    logic             hit_stat;
    logic             hit_any;
    logic             wr;
    logic             wr_test;
    logic             wr_did;
    logic             wr_frame_end;
    logic             wr_stat;

    // A pending ack or err blocks a second take of the same request
    assign req           = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    // Byte address; the two low bits select a byte and are ignored
    assign idx           = wb_adr_i[ADR_W-1:2];
    assign hit_test      = idx == `SLTF_IDX_TEST;
    assign hit_did       = idx == `SLTF_IDX_DID;
    assign hit_frame_end = idx == `SLTF_IDX_FRAME_END;
    assign hit_stat      = idx == `SLTF_IDX_STATUS;
    assign hit_any       = hit_test || hit_did || hit_frame_end || hit_stat;

    // ------------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------------
    // Every field sits in byte lane 0, so only sel[0] can enable a write;
    // a write with it low is still acknowledged but changes nothing
    assign wr            = req && hit_any && wb_we_i && wb_sel_i[0];
    assign wr_test       = wr && hit_test;
    assign wr_did        = wr && hit_did;
    assign wr_frame_end  = wr && hit_frame_end;
    assign wr_stat       = wr && hit_stat;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // No shadow copies: software only rewrites these while the link is
    // disabled, so the lane logic may see a new value on any cycle
    logic [4:0] test_pattern_select_q;
    logic [7:0] did_q;
    logic [1:0] frame_end_comma_select_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_pattern_select_q <= `SLTF_RST_TEST;
        end else if (wr_test) begin
            test_pattern_select_q <= wb_dat_i[4:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            did_q <= `SLTF_RST_DID;
        end else if (wr_did) begin
            // Bit zero is dropped here, so reads and both links agree
            did_q <= {wb_dat_i[7:1], 1'b0};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_end_comma_select_q <= `SLTF_RST_FRAME_END;
        end else if (wr_frame_end) begin
            frame_end_comma_select_q <= wb_dat_i[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    logic armed_q;
    logic multiframe_phase_set_flag_q;
    logic realigned_q;
    logic set_multiframe_phase_set_flag;
    logic set_realigned;
    logic clr_multiframe_phase_set_flag;
    logic clr_realigned;

    assign set_multiframe_phase_set_flag   = link_enable_i && armed_q && link_i.sysref_event;
    assign set_realigned = link_i.sysref_event && link_i.phase_shift;
    assign clr_multiframe_phase_set_flag   = wr_stat && wb_dat_i[`SLTF_STAT_MULTIFRAME_PHASE_SET_FLAG];
    assign clr_realigned = wr_stat && wb_dat_i[`SLTF_STAT_REALIGN];

    // Armed while the link is off, so only the first event after enabling
    // sets multiframe_phase_set_flag; reset leaves it armed because nothing has multiframe_phase_set_flag yet
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed_q <= 1'b1;
        end else if (!link_enable_i) begin
            armed_q <= 1'b1;
        end else if (link_i.sysref_event) begin
            armed_q <= 1'b0;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            multiframe_phase_set_flag_q <= 1'b0;
        end else if (set_multiframe_phase_set_flag) begin
            multiframe_phase_set_flag_q <= 1'b1;
        end else if (clr_multiframe_phase_set_flag) begin
            multiframe_phase_set_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            realigned_q <= 1'b0;
        end else if (set_realigned) begin
            realigned_q <= 1'b1;
        end else if (clr_realigned) begin
            realigned_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    // Link up, sync and lock are live levels, not latched, so a read
    // shows the link as it stands; only the two event flags are sticky
    logic [7:0] status;

    always_comb begin
        status = 8'h00;
        status[`SLTF_STAT_LINK_UP] = link_i.link_up;
        status[`SLTF_STAT_SYNC]    = link_i.sync_req_n;
        status[`SLTF_STAT_REALIGN] = realigned_q;
        status[`SLTF_STAT_MULTIFRAME_PHASE_SET_FLAG] = multiframe_phase_set_flag_q;
        status[`SLTF_STAT_LOCK]    = link_i.pll_locked;
    end

    // ------------------------------------------------------------------
    // Bus answer: one cycle after request, unmapped gets err
    // ------------------------------------------------------------------
    // Fixed single wait state; a write lands at the take edge, so it is
    // already visible by the time the master sees ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= req && hit_any;
            wb_err_o <= req && !hit_any;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            // Upper and reserved bits always read as zero
            wb_dat_o <= 32'h0000_0000;
            if (hit_test) begin
                wb_dat_o[4:0] <= test_pattern_select_q;
            end
            if (hit_did) begin
                wb_dat_o[7:0] <= did_q;
            end
            if (hit_frame_end) begin
                wb_dat_o[1:0] <= frame_end_comma_select_q;
            end
            if (hit_stat) begin
                wb_dat_o[7:0] <= status;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pattern decode
    // ------------------------------------------------------------------
    sltf_cfg_t  cfg_d;
    logic [7:0] fe_char;

    // ------------------------------------------------------------------
    // Frame-end character
    // ------------------------------------------------------------------
    // Reserved code 3 falls back to the standard character rather than
    // sending something a receiver could mistake for a comma
    always_comb begin
        case (frame_end_comma_select_q)
            2'h0:    fe_char = `SLTF_K28_7;
            2'h1:    fe_char = `SLTF_K28_1;
            2'h2:    fe_char = `SLTF_K28_5;
            default: fe_char = `SLTF_K28_7;
        endcase
    end

    // ------------------------------------------------------------------
    // Test pattern select
    // ------------------------------------------------------------------
    // Everything not named below stays zero, so fields that a source
    // does not use never carry stale values into the lane logic
    always_comb begin
        cfg_d             = '0;
        cfg_d.source      = SLTF_SRC_DATA;
        cfg_d.prbs        = SLTF_PRBS_NONE;
        cfg_d.did_link_a  = did_q;
        // The identifier is even, so the sum below never wraps
        cfg_d.did_link_b  = did_q + 8'h01;
        cfg_d.frame_end_char = fe_char;
        cfg_d.frame_end_en   = link_mode_8b10b_i;
        case (test_pattern_select_q)
            `SLTF_TP_OFF: begin
                cfg_d.source = SLTF_SRC_DATA;
                cfg_d.prbs   = SLTF_PRBS_NONE;
            end
            `SLTF_TP_PRBS7: begin
                cfg_d.source = SLTF_SRC_PRBS;
                cfg_d.prbs   = SLTF_PRBS_7;
            end
            `SLTF_TP_PRBS15: begin
                cfg_d.source = SLTF_SRC_PRBS;
                cfg_d.prbs   = SLTF_PRBS_15;
            end
            `SLTF_TP_PRBS23: begin
                cfg_d.source = SLTF_SRC_PRBS;
                cfg_d.prbs   = SLTF_PRBS_23;
            end
            `SLTF_TP_PRBS9: begin
                cfg_d.source = SLTF_SRC_PRBS;
                cfg_d.prbs   = SLTF_PRBS_9;
            end
            `SLTF_TP_PRBS31: begin
                cfg_d.source = SLTF_SRC_PRBS;
                cfg_d.prbs   = SLTF_PRBS_31;
            end
            `SLTF_TP_RAMP: begin
                cfg_d.source = SLTF_SRC_RAMP;
            end
            `SLTF_TP_TRANSPORT: begin
                cfg_d.source = SLTF_SRC_TRANSPORT;
            end
            `SLTF_TP_D215: begin
                cfg_d.source    = SLTF_SRC_CHAR;
                cfg_d.char_code = `SLTF_D21_5;
                cfg_d.char_is_k = 1'b0; // data character, not control
            end
            `SLTF_TP_K285: begin
                cfg_d.source    = SLTF_SRC_CHAR;
                cfg_d.char_code = `SLTF_K28_5;
                cfg_d.char_is_k = 1'b1;
            end
            `SLTF_TP_ILA: begin
                cfg_d.source = SLTF_SRC_ILA;
            end
            `SLTF_TP_RPAT: begin
                cfg_d.source = SLTF_SRC_RPAT;
            end
            `SLTF_TP_K287: begin
                cfg_d.source    = SLTF_SRC_CHAR;
                cfg_d.char_code = `SLTF_K28_7;
                cfg_d.char_is_k = 1'b1;
            end
            `SLTF_TP_LOW: begin
                cfg_d.source      = SLTF_SRC_LOW;
                cfg_d.static_word = 16'h0000;
            end
            `SLTF_TP_HIGH: begin
                cfg_d.source      = SLTF_SRC_HIGH;
                cfg_d.static_word = 16'hFFFF;
            end
            `SLTF_TP_CLOCK: begin
                cfg_d.source      = SLTF_SRC_CLOCK;
                cfg_d.static_word = `SLTF_CLOCK_WORD;
            end
            // Reserved codes fall back to normal data, the safest output
            // if software breaks the rule and writes one
            default: begin
                cfg_d.source = SLTF_SRC_DATA;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    // One register stage keeps the wide decode off the lane logic's path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_o <= '0;
        end else begin
            cfg_o <= cfg_d;
        end
    end

    // Frame end replaces the last character only when the link layer
    // reports the replacement conditions met, never on 64b/66b
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_end_insert_o <= 1'b0;
        end else begin
            frame_end_insert_o <= frame_end_ok_i && link_mode_8b10b_i
                                  && link_enable_i;
        end
    end

endmodule : sltf_top

// ### bench/sltf_properties.sv
`timescale 1ns/1ps
module sltf_properties #(
    parameter int ADR_W = 14
) (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [ADR_W-1:0]    wb_adr_i,
    input wire logic [31:0]         wb_dat_o,
    input wire logic                wb_ack_o,
    input wire logic                wb_err_o,
    input wire logic                link_enable_i,
    input wire logic                link_mode_8b10b_i,
    input wire logic                frame_end_ok_i,
    input wire sltf_pkg::sltf_cfg_t cfg_o,
    input wire logic                frame_end_insert_o
);
    import sltf_pkg::*;
    logic             take;
    logic             mapped;
    logic [ADR_W-3:0] idx;
    assign idx    = wb_adr_i[ADR_W-1:2];
    assign take   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign mapped = idx >= 12'h205 && idx <= 12'h208;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // Bus answers and decoded configuration
    // ------------------------------------------------------------
    AST_ANSWER:
    assert property (take && mapped |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acknowledged");
    AST_UNMAPPED:
    assert property (take && !mapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    AST_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_RESV:
    assert property (wb_ack_o && $past(idx) == 12'h208 && !$past(wb_we_i)
        |-> wb_dat_o[31:7] == 25'h0 && wb_dat_o[1:0] == 2'h0)
        else $error("status reserved bits set");
    AST_INSERT:
    assert property (!$past(rst_i) |-> frame_end_insert_o ==
        $past(frame_end_ok_i && link_mode_8b10b_i && link_enable_i))
        else $error("frame end insert wrong");
    AST_MODE:
    assert property (!$past(rst_i)
        |-> cfg_o.frame_end_en == $past(link_mode_8b10b_i))
        else $error("frame end enable ignores mode");
    AST_PLUS_ONE:
    assert property (!$past(rst_i)
        |-> cfg_o.did_link_b == cfg_o.did_link_a + 8'h01)
        else $error("second link identifier wrong");
    AST_EVEN:
    assert property (cfg_o.did_link_a[0] == 1'b0)
        else $error("identifier bit zero set");
    AST_CLOCK:
    assert property (cfg_o.source == SLTF_SRC_CLOCK
        |-> cfg_o.static_word == 16'h00FF)
        else $error("clock word wrong");
    cover property (take && !mapped);
    cover property (frame_end_insert_o);
    cover property (cfg_o.source == SLTF_SRC_CLOCK);
endmodule : sltf_properties
bind sltf_top sltf_properties #(.ADR_W(ADR_W)) u_props (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .link_enable_i,
    .link_mode_8b10b_i, .frame_end_ok_i, .cfg_o, .frame_end_insert_o
);

// ### bench/sltf_rx_model.sv
`timescale 1ns/1ps
module sltf_rx_model #(
    parameter int LOCK_CYC = 8,
    parameter int SYNC_CYC = 6
) (
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           link_enable_i,
    input  wire logic           sysref_i,
    input  wire logic           shift_i,
    output sltf_pkg::sltf_link_t link_o
);
    import sltf_pkg::*;
    int lock_q;
    int sync_q;
    // ------------------------------------------------------------
    // Receiver holds sync request until the link runs a while
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_q <= 0;
            sync_q <= 0;
            link_o <= '0;
        end else begin
            lock_q <= (lock_q < LOCK_CYC) ? lock_q + 1 : lock_q;
            sync_q <= !link_enable_i ? 0 :
                      (sync_q < SYNC_CYC) ? sync_q + 1 : sync_q;
            link_o.pll_locked   <= lock_q >= LOCK_CYC;
            link_o.sync_req_n   <= sync_q >= SYNC_CYC;
            link_o.link_up      <= sync_q >= SYNC_CYC;
            link_o.sysref_event <= sysref_i;
            link_o.phase_shift  <= shift_i;
        end
    end
endmodule : sltf_rx_model

// ### bench/tb_sltf_top.sv
`timescale 1ns/1ps
module tb_sltf_top;
    import sltf_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i, cyc, stb, we, ack, err, got_err, ins;
    logic        en, mode, ok, sref, shift;
    logic [13:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat, dat_o, rdat;
    logic [15:0] e;
    logic [7:0]  fc [3] = '{8'hFC, 8'h3C, 8'hBC};
    logic [7:0]  dv [3] = '{8'h37, 8'hFF, 8'h01};
    sltf_link_t  link;
    sltf_cfg_t   cfg;
    int          failures, checks_done, cycles;
    always #5 clk_i = ~clk_i;
    sltf_top DUT (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
        .link_enable_i(en), .link_mode_8b10b_i(mode),
        .frame_end_ok_i(ok), .link_i(link), .cfg_o(cfg),
        .frame_end_insert_o(ins));
    sltf_rx_model u_rx (.clk_i, .rst_i, .link_enable_i(en),
        .sysref_i(sref), .shift_i(shift), .link_o(link));
    // ------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [11:0] i,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {i, 2'h0};
        wdat <= d;
        sel  <= s;
        do @(posedge clk_i); while (!(ack === 1'b1 || err === 1'b1));
        rdat    = dat_o;
        got_err = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic rd(input logic [11:0] i, input logic [31:0] exp);
        bus(1'b0, i, 32'h0, 4'hF);
        check(rdat, exp);
    endtask : rd
    task automatic pulse(input logic s);
        @(posedge clk_i);
        sref  <= 1'b1;
        shift <= s;
        @(posedge clk_i);
        sref  <= 1'b0;
        shift <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : pulse
    function automatic logic [15:0] pat(input logic [4:0] c);
        case (c)
            5'h01: pat = {SLTF_SRC_PRBS, SLTF_PRBS_7, 9'h0};
            5'h02: pat = {SLTF_SRC_PRBS, SLTF_PRBS_15, 9'h0};
            5'h03: pat = {SLTF_SRC_PRBS, SLTF_PRBS_23, 9'h0};
            5'h04: pat = {SLTF_SRC_RAMP, SLTF_PRBS_NONE, 9'h0};
            5'h05: pat = {SLTF_SRC_TRANSPORT, SLTF_PRBS_NONE, 9'h0};
            5'h06: pat = {SLTF_SRC_CHAR, SLTF_PRBS_NONE, 9'h16A};
            5'h07: pat = {SLTF_SRC_CHAR, SLTF_PRBS_NONE, 9'h179};
            5'h08: pat = {SLTF_SRC_ILA, SLTF_PRBS_NONE, 9'h0};
            5'h09: pat = {SLTF_SRC_RPAT, SLTF_PRBS_NONE, 9'h0};
            5'h0A: pat = {SLTF_SRC_LOW, SLTF_PRBS_NONE, 9'h0};
            5'h0B: pat = {SLTF_SRC_HIGH, SLTF_PRBS_NONE, 9'h0};
            5'h0D: pat = {SLTF_SRC_PRBS, SLTF_PRBS_9, 9'h0};
            5'h0E: pat = {SLTF_SRC_PRBS, SLTF_PRBS_31, 9'h0};
            5'h0F: pat = {SLTF_SRC_CLOCK, SLTF_PRBS_NONE, 9'h0};
            5'h10: pat = {SLTF_SRC_CHAR, SLTF_PRBS_NONE, 9'h1F9};
            default: pat = {SLTF_SRC_DATA, SLTF_PRBS_NONE, 9'h0};
        endcase
    endfunction : pat
    task automatic final_report;
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 5000) begin
            failures++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_i, cyc, stb, we, en, ok, sref, shift} = 8'h80;
        {adr, sel, wdat} = '0;
        mode = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(12'h205, 32'h0);
        rd(12'h206, 32'h0);
        rd(12'h207, 32'h0);
        for (int c = 0; c < 17; c++) begin
            if (c == 12) continue;
            bus(1'b1, 12'h205, c, 4'hF);
            repeat (2) @(posedge clk_i);
            e = pat(5'(c));
            check({cfg.source, cfg.prbs}, e[15:9]);
            if (e[15:12] == SLTF_SRC_CHAR)
                check({cfg.char_code, cfg.char_is_k}, e[8:0]);
            if (c == 15)
                check(cfg.static_word, 16'h00FF);
            if (c == 10 || c == 11)
                check(cfg.static_word, {16{c == 11}});
            rd(12'h205, c);
        end
        foreach (dv[k]) begin
            bus(1'b1, 12'h206, dv[k], 4'hF);
            rd(12'h206, dv[k] & 8'hFE);
            check(cfg.did_link_b, (dv[k] & 8'hFE) + 8'h01);
        end
        bus(1'b1, 12'h206, 32'hAA, 4'h0);
        rd(12'h206, 32'h00);
        for (int v = 0; v < 3; v++) begin
            bus(1'b1, 12'h207, v, 4'hF);
            @(posedge clk_i);
            check(cfg.frame_end_char, fc[v]);
        end
        bus(1'b1, 12'h207, 32'h0, 4'hF);
        rd(12'h208, 32'h04);
        bus(1'b0, 12'h209, 32'h0, 4'hF);
        check(got_err, 1'b1);
        ok <= 1'b1;
        en <= 1'b1;
        repeat (2) @(posedge clk_i);
        check(ins, 1'b1);
        mode <= 1'b0;
        repeat (2) @(posedge clk_i);
        check({ins, cfg.frame_end_en}, 2'h0);
        ok   <= 1'b0;
        mode <= 1'b1;
        repeat (12) @(posedge clk_i);
        check(ins, 1'b0);
        rd(12'h208, 32'h64);
        pulse(1'b0);
        rd(12'h208, 32'h6C);
        pulse(1'b1);
        rd(12'h208, 32'h7C);
        bus(1'b1, 12'h208, 32'h18, 4'hF);
        rd(12'h208, 32'h64);
        pulse(1'b0);
        rd(12'h208, 32'h64);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(12'h205, 32'h0);
        check({cfg.source, cfg.prbs}, 7'h00);
        final_report();
    end
endmodule : tb_sltf_top
